// *** verilog/tpw_timer.sv ***
// apb-mapped 8-bit timer with fast and phase correct pwm generation
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tpw_timer
   import tpw_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             waveOutA,
   output logic             waveOutB,
   output logic             pinOutA,
   output logic             pinOeA,
   output logic             pinOutB,
   output logic             pinOeB
);
   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic [2:0]  waveModeSelect_reg;
   logic [1:0]  actionModeA_reg;
   logic [1:0]  actionModeB_reg;
   logic [2:0]  clockSelect_reg;
   logic [7:0]  countValue_reg;
   logic [7:0]  countValue_next;
   tpw_dir_t    dir_reg;
   tpw_dir_t    dir_next;
   logic [7:0]  cmpABuf_reg;
   logic [7:0]  cmpBBuf_reg;
   logic [7:0]  cmpAActive_reg;
   logic [7:0]  cmpBActive_reg;
   logic        overflowFlag_reg;
   logic        matchFlagA_reg;
   logic        matchFlagB_reg;
   logic [3:0]  portCtrl_reg;
   logic        timerTick;
   logic        isFast;
   logic        isPhase;
   logic        isPwm;
   logic        isCtc;
   logic        waveModeBit2;
   logic [7:0]  topValue;
   logic        atTop;
   logic        atBottomTurn;
   logic        upPhase;
   logic        matchA;
   logic        matchB;
   logic        ovfEvent;
   logic        connectedA;
   logic        connectedB;
   logic        wrEn;
   logic        rdEn;
   logic        addrOk;
   logic        countWrite;

   // ---------------------------------------------------------------
   // mode decode
   // ---------------------------------------------------------------
   assign isFast = (waveModeSelect_reg == TPW_WAVE_FP_FF)
                   || (waveModeSelect_reg == TPW_WAVE_FP_OCA);
   assign isPhase = (waveModeSelect_reg == TPW_WAVE_PC_FF)
                    || (waveModeSelect_reg == TPW_WAVE_PC_OCA);
   assign isPwm = isFast || isPhase;
   assign isCtc = (waveModeSelect_reg == TPW_WAVE_CTC);
   assign waveModeBit2 = waveModeSelect_reg[2];

   // top from compare a only in modes 5 and 7 and ctc
   assign topValue = ((isPwm && waveModeBit2) || isCtc) ? cmpAActive_reg : TPW_MAX;
   assign atTop = (countValue_reg == topValue) && (!isPhase || dir_reg == TPW_UP);
   assign atBottomTurn = isPhase && (countValue_reg == TPW_BOTTOM) && (dir_reg == TPW_DOWN);
   // bottom belongs to the up slope so compare zero never sets on the way down
   assign upPhase = (dir_reg == TPW_UP) || (countValue_reg == TPW_BOTTOM);
   assign matchA = (countValue_reg == cmpAActive_reg);
   assign matchB = (countValue_reg == cmpBActive_reg);

   // ---------------------------------------------------------------
   // apb slave
   // ---------------------------------------------------------------
   assign addrOk = (paddr == TPW_OFS_CTRL) || (paddr == TPW_OFS_COUNT)
                   || (paddr == TPW_OFS_CMPA) || (paddr == TPW_OFS_CMPB)
                   || (paddr == TPW_OFS_STATUS) || (paddr == TPW_OFS_PORT);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addrOk;
   assign wrEn = psel && penable && pwrite && addrOk;
   assign rdEn = psel && penable && !pwrite;
   assign countWrite = wrEn && (paddr == TPW_OFS_COUNT);

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         prdata <= TPW_RST_REG;
      else if (rdEn)
      begin
         unique case (paddr)
            TPW_OFS_CTRL:   prdata <= {21'h0, clockSelect_reg, actionModeB_reg, actionModeA_reg,
                                       1'b0, waveModeSelect_reg};
            TPW_OFS_COUNT:  prdata <= {24'h000000, countValue_reg};
            TPW_OFS_CMPA:   prdata <= {24'h000000, cmpABuf_reg};
            TPW_OFS_CMPB:   prdata <= {24'h000000, cmpBBuf_reg};
            TPW_OFS_STATUS: prdata <= {29'h0, matchFlagB_reg, matchFlagA_reg, overflowFlag_reg};
            TPW_OFS_PORT:   prdata <= {28'h0000000, portCtrl_reg};
            default:        prdata <= TPW_RST_REG;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         waveModeSelect_reg <= TPW_RST_REG[2:0];
         actionModeA_reg    <= TPW_RST_REG[1:0];
         actionModeB_reg    <= TPW_RST_REG[1:0];
         clockSelect_reg    <= TPW_RST_REG[2:0];
      end
      else if (wrEn && paddr == TPW_OFS_CTRL)
      begin
         waveModeSelect_reg <= pwdata[TPW_CTRL_WAVE_LSB +: 3];
         actionModeA_reg    <= pwdata[TPW_CTRL_ACTA_LSB +: 2];
         actionModeB_reg    <= pwdata[TPW_CTRL_ACTB_LSB +: 2];
         clockSelect_reg    <= pwdata[TPW_CTRL_CLK_LSB +: 3];
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         portCtrl_reg <= TPW_RST_REG[3:0];
      else if (wrEn && paddr == TPW_OFS_PORT)
         portCtrl_reg <= pwdata[3:0];
   end

   // ---------------------------------------------------------------
   // compare buffers and active compare values
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         cmpABuf_reg <= TPW_RST_REG[7:0];
         cmpBBuf_reg <= TPW_RST_REG[7:0];
      end
      else
      begin
         if (wrEn && paddr == TPW_OFS_CMPA)
            cmpABuf_reg <= pwdata[7:0];
         if (wrEn && paddr == TPW_OFS_CMPB)
            cmpBBuf_reg <= pwdata[7:0];
      end
   end

   // pwm loads only at top so a period never sees a half-updated compare
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         cmpAActive_reg <= TPW_RST_REG[7:0];
         cmpBActive_reg <= TPW_RST_REG[7:0];
      end
      else if (!isPwm || (timerTick && atTop))
      begin
         cmpAActive_reg <= cmpABuf_reg;
         cmpBActive_reg <= cmpBBuf_reg;
      end
   end

   // ---------------------------------------------------------------
   // prescaler
   // ---------------------------------------------------------------
   tpw_prescaler u_prescaler (
      .mclk        (mclk),
      .nrst        (nrst),
      .clockSelect (clockSelect_reg),
      .timerTick   (timerTick)
   );

   // ---------------------------------------------------------------
   // counter
   // ---------------------------------------------------------------
   always_comb
   begin
      countValue_next = countValue_reg;
      dir_next = dir_reg;
      if (isPhase)
      begin
         if (dir_reg == TPW_UP && countValue_reg >= topValue)
         begin
            dir_next = TPW_DOWN;
            countValue_next = countValue_reg - 8'h01;
         end
         else if (dir_reg == TPW_DOWN && countValue_reg == TPW_BOTTOM)
         begin
            dir_next = TPW_UP;
            countValue_next = 8'h01;
         end
         else if (dir_reg == TPW_UP)
            countValue_next = countValue_reg + 8'h01;
         else
            countValue_next = countValue_reg - 8'h01;
      end
      else
      begin
         dir_next = TPW_UP;
         if (countValue_reg == topValue)
            countValue_next = TPW_BOTTOM;
         else
            countValue_next = countValue_reg + 8'h01;
      end
   end

   // software write wins over a same-cycle tick
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         countValue_reg <= TPW_RST_REG[7:0];
         dir_reg        <= TPW_UP;
      end
      else if (countWrite)
         countValue_reg <= pwdata[7:0];
      else if (timerTick)
      begin
         countValue_reg <= countValue_next;
         dir_reg        <= dir_next;
      end
   end

   // ---------------------------------------------------------------
   // status flags, write one to clear, a new event beats the clear
   // ---------------------------------------------------------------
   always_comb
   begin
      if (isFast)
         ovfEvent = atTop;
      else if (isPhase)
         ovfEvent = atBottomTurn;
      else
         ovfEvent = (countValue_reg == TPW_MAX);
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         overflowFlag_reg <= 1'b0;
         matchFlagA_reg   <= 1'b0;
         matchFlagB_reg   <= 1'b0;
      end
      else
      begin
         if (timerTick && ovfEvent)
            overflowFlag_reg <= 1'b1;
         else if (wrEn && paddr == TPW_OFS_STATUS && pwdata[TPW_ST_OVF])
            overflowFlag_reg <= 1'b0;
         if (timerTick && matchA)
            matchFlagA_reg <= 1'b1;
         else if (wrEn && paddr == TPW_OFS_STATUS && pwdata[TPW_ST_MATCHA])
            matchFlagA_reg <= 1'b0;
         if (timerTick && matchB)
            matchFlagB_reg <= 1'b1;
         else if (wrEn && paddr == TPW_OFS_STATUS && pwdata[TPW_ST_MATCHB])
            matchFlagB_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // compare output channels
   // ---------------------------------------------------------------
   tpw_channel u_chanA (
      .mclk         (mclk),
      .nrst         (nrst),
      .tick         (timerTick),
      .isFast       (isFast),
      .isPhase      (isPhase),
      .actionMode   (actionModeA_reg),
      .toggleOk     (waveModeBit2),
      .atTop        (atTop),
      .atBottomTurn (atBottomTurn),
      .upPhase      (upPhase),
      .match        (matchA),
      .cmpIsTop     (cmpAActive_reg == topValue),
      .waveOut      (waveOutA),
      .connected    (connectedA)
   );

   // channel b has no pwm toggle option
   tpw_channel u_chanB (
      .mclk         (mclk),
      .nrst         (nrst),
      .tick         (timerTick),
      .isFast       (isFast),
      .isPhase      (isPhase),
      .actionMode   (actionModeB_reg),
      .toggleOk     (1'b0),
      .atTop        (atTop),
      .atBottomTurn (atBottomTurn),
      .upPhase      (upPhase),
      .match        (matchB),
      .cmpIsTop     (cmpBActive_reg == topValue),
      .waveOut      (waveOutB),
      .connected    (connectedB)
   );

   // ---------------------------------------------------------------
   // port override
   // ---------------------------------------------------------------
   // the internal register keeps running even while the pin is an input
   assign pinOutA = connectedA ? waveOutA : portCtrl_reg[TPW_PORT_DATA];
   assign pinOutB = connectedB ? waveOutB : portCtrl_reg[TPW_PORT_DATB];
   assign pinOeA  = portCtrl_reg[TPW_PORT_DIRA];
   assign pinOeB  = portCtrl_reg[TPW_PORT_DIRB];
endmodule
`default_nettype wire

// *** verilog/tpw_pkg.sv ***
// constants shared by the 8-bit timer pwm waveform generator
`default_nettype none
package tpw_pkg;
   // ---------------------------------------------------------------
   // register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] TPW_OFS_CTRL   = 8'h00;
   localparam logic [7:0] TPW_OFS_COUNT  = 8'h04;
   localparam logic [7:0] TPW_OFS_CMPA   = 8'h08;
   localparam logic [7:0] TPW_OFS_CMPB   = 8'h0c;
   localparam logic [7:0] TPW_OFS_STATUS = 8'h10;
   localparam logic [7:0] TPW_OFS_PORT   = 8'h14;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int TPW_CTRL_WAVE_LSB = 0;
   localparam int TPW_CTRL_ACTA_LSB = 4;
   localparam int TPW_CTRL_ACTB_LSB = 6;
   localparam int TPW_CTRL_CLK_LSB  = 8;
   localparam int TPW_ST_OVF        = 0;
   localparam int TPW_ST_MATCHA     = 1;
   localparam int TPW_ST_MATCHB     = 2;
   localparam int TPW_PORT_DIRA     = 0;
   localparam int TPW_PORT_DIRB     = 1;
   localparam int TPW_PORT_DATA     = 2;
   localparam int TPW_PORT_DATB     = 3;
   // ---------------------------------------------------------------
   // reset values and fixed levels
   // ---------------------------------------------------------------
   localparam logic [31:0] TPW_RST_REG = 32'h0000_0000;
   localparam logic [7:0]  TPW_MAX     = 8'hff;
   localparam logic [7:0]  TPW_BOTTOM  = 8'h00;
   // ---------------------------------------------------------------
   // waveform modes, output actions, prescale choices
   // ---------------------------------------------------------------
   localparam logic [2:0] TPW_WAVE_NORMAL = 3'h0;
   localparam logic [2:0] TPW_WAVE_PC_FF  = 3'h1;
   localparam logic [2:0] TPW_WAVE_CTC    = 3'h2;
   localparam logic [2:0] TPW_WAVE_FP_FF  = 3'h3;
   localparam logic [2:0] TPW_WAVE_PC_OCA = 3'h5;
   localparam logic [2:0] TPW_WAVE_FP_OCA = 3'h7;
   localparam logic [1:0] TPW_ACT_OFF     = 2'h0;
   localparam logic [1:0] TPW_ACT_TOGGLE  = 2'h1;
   localparam logic [1:0] TPW_ACT_CLEAR   = 2'h2;
   localparam logic [1:0] TPW_ACT_SET     = 2'h3;
   localparam int TPW_PRESCALE_WIDTH = 10;
   localparam logic [9:0] TPW_DIV8    = 10'h007;
   localparam logic [9:0] TPW_DIV64   = 10'h03f;
   localparam logic [9:0] TPW_DIV256  = 10'h0ff;
   localparam logic [9:0] TPW_DIV1024 = 10'h3ff;
   typedef enum logic {TPW_UP, TPW_DOWN} tpw_dir_t;
endpackage
`default_nettype wire

// *** verilog/tpw_prescaler.sv ***
// prescaler producing the one-cycle timer tick enable
`timescale 1ns/1ps
`default_nettype none
module tpw_prescaler
   import tpw_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic [2:0] clockSelect,
   output logic            timerTick
);
   logic [9:0] preCnt_reg;
   logic [9:0] divMask;

   always_comb
   begin
      unique case (clockSelect)
         3'h2:    divMask = TPW_DIV8;
         3'h3:    divMask = TPW_DIV64;
         3'h4:    divMask = TPW_DIV256;
         3'h5:    divMask = TPW_DIV1024;
         default: divMask = 10'h000;
      endcase
   end

   // free running; the tick lands when all masked bits are ones
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         preCnt_reg <= 10'h000;
      else
         preCnt_reg <= preCnt_reg + 10'h001;
   end

   // select 0 and 6..7 stop the timer
   assign timerTick = (clockSelect != 3'h0) && (clockSelect <= 3'h5)
                      && ((preCnt_reg & divMask) == divMask);
endmodule
`default_nettype wire

// *** verilog/tpw_channel.sv ***
// one compare output register with its set, clear and toggle actions
`timescale 1ns/1ps
`default_nettype none
module tpw_channel
   import tpw_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic       tick,
   input  wire logic       isFast,
   input  wire logic       isPhase,
   input  wire logic [1:0] actionMode,
   input  wire logic       toggleOk,
   input  wire logic       atTop,
   input  wire logic       atBottomTurn,
   input  wire logic       upPhase,
   input  wire logic       match,
   input  wire logic       cmpIsTop,
   output logic            waveOut,
   output logic            connected
);
   logic upSeen_reg;
   logic missedUp_reg;
   logic isPwm;
   logic inverted;
   logic upLevel;

   assign isPwm    = isFast || isPhase;
   assign inverted = (actionMode == TPW_ACT_SET);
   // level left behind by an up-count match
   assign upLevel  = inverted;

   // mode 1 in pwm is a toggle only where allowed, else disconnected
   assign connected = (actionMode != TPW_ACT_OFF)
                      && !(isPwm && actionMode == TPW_ACT_TOGGLE && !toggleOk);

   // ---------------------------------------------------------------
   // output register
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         waveOut <= 1'b0;
      else if (tick && actionMode == TPW_ACT_TOGGLE)
      begin
         if (match && (!isPwm || toggleOk))
            waveOut <= !waveOut;
      end
      else if (tick && actionMode[1] && isFast)
      begin
         if (atTop)
            waveOut <= !inverted;
         else if (match)
            waveOut <= inverted;
      end
      else if (tick && actionMode[1] && isPhase)
      begin
         if (atTop && cmpIsTop)
            waveOut <= !inverted;
         else if (atBottomTurn && (match || missedUp_reg) && !cmpIsTop)
            waveOut <= upLevel;
         else if (match && !atTop)
            waveOut <= upPhase ? upLevel : !upLevel;
      end
      else if (tick && actionMode[1] && match)
         waveOut <= actionMode[0];
   end

   // ---------------------------------------------------------------
   // missed up-count match tracking
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         upSeen_reg   <= 1'b0;
         missedUp_reg <= 1'b0;
      end
      else if (tick && isPhase)
      begin
         if (atBottomTurn)
            upSeen_reg <= match;
         else if (match && upPhase && !atTop)
            upSeen_reg <= 1'b1;
         if (atTop)
            missedUp_reg <= !upSeen_reg || cmpIsTop;
      end
   end
endmodule
`default_nettype wire

// *** test/tpw_timer_props.sv ***
// port-level property checker for the pwm timer
`timescale 1ns/1ps
`default_nettype none
module tpw_timer_chk
   import tpw_pkg::*;
(
   input wire logic        mclk,
   input wire logic        nrst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        waveOutA,
   input wire logic        waveOutB,
   input wire logic        pinOutA,
   input wire logic        pinOeA,
   input wire logic        pinOutB,
   input wire logic        pinOeB
);
   logic [31:0] ctrlReg;
   logic [31:0] portReg;
   logic        wrEn;
   logic        pwm;
   logic        stopped;
   logic        refusedA;
   assign wrEn    = psel && penable && pwrite;
   // channel a toggle needs mode bit 2 in pwm
   assign refusedA = pwm && !ctrlReg[2] && ctrlReg[5:4] == TPW_ACT_TOGGLE;
   assign pwm     = ctrlReg[TPW_CTRL_WAVE_LSB];
   assign stopped = ctrlReg[10:8] == 3'h0 || ctrlReg[10:8] > 3'h5;
   // ---------------------------------------------------------------
   // shadow of the control and port registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrlReg <= TPW_RST_REG;
         portReg <= TPW_RST_REG;
      end
      else if (wrEn && paddr == TPW_OFS_CTRL)
         ctrlReg <= pwdata;
      else if (wrEn && paddr == TPW_OFS_PORT)
         portReg <= pwdata;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   AST_READY: assert property (psel && penable |-> pready) else $error("access without ready");
   AST_ERR: assert property (psel && penable && (paddr > TPW_OFS_PORT || paddr[1:0] != 2'h0) |-> pslverr)
      else $error("unmapped access not refused");
   AST_NOERR: assert property (!psel |-> !pslverr) else $error("error outside a transfer");
   AST_OE_A: assert property (pinOeA == portReg[TPW_PORT_DIRA]) else $error("pin a enable wrong");
   AST_OE_B: assert property (pinOeB == portReg[TPW_PORT_DIRB]) else $error("pin b enable wrong");
   AST_PIN_A_OFF: assert property (ctrlReg[5:4] == TPW_ACT_OFF |-> pinOutA == portReg[TPW_PORT_DATA])
      else $error("pin a not under port control");
   AST_PIN_A_PWM: assert property (pwm && ctrlReg[5] |-> pinOutA == waveOutA)
      else $error("pin a not showing waveform");
   AST_B_NOTOG: assert property (pwm && ctrlReg[7:6] == TPW_ACT_TOGGLE |-> pinOutB == portReg[TPW_PORT_DATB])
      else $error("pin b toggle not refused");
   AST_A_NOTOG: assert property (refusedA |-> pinOutA == portReg[TPW_PORT_DATA])
      else $error("pin a toggle not refused");
   AST_STOP: assert property (stopped [*3] |=> $stable(waveOutA) && $stable(waveOutB))
      else $error("output moved without tick");
endmodule
bind tpw_timer tpw_timer_chk u_chk (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .waveOutA(waveOutA), .waveOutB(waveOutB),
   .pinOutA(pinOutA), .pinOeA(pinOeA), .pinOutB(pinOutB), .pinOeB(pinOeB));
`default_nettype wire

// *** test/tpw_pad_load.sv ***
// pad model for a compare output pin with a weak pull-up
`timescale 1ns/1ps
`default_nettype none
module tpw_pad_load
(
   input  wire logic pinOut,
   input  wire logic pinOe,
   output logic      padLevel
);
   // an undriven pad goes to the pull-up level, never keeps the old value
   assign padLevel = pinOe ? pinOut : 1'b1;
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// self-checking testbench for the pwm timer
`timescale 1ns/1ps
`default_nettype none
module testbench
   import tpw_pkg::*;
;
   logic        mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata, rv;
   logic        pready, pslverr, waveOutA, waveOutB, pinOutA, pinOeA, pinOutB, pinOeB, padA, padB, er;
   int          bad_count = 0, samples_checked = 0, seed = 32'h41fb6613;
   int          i, ca, cb, top, base, fac, win, hiA, hiB;
   int          mTab [7] = '{3, 3, 1, 1, 7, 5, 3};
   int          aTab [7] = '{2, 3, 2, 3, 1, 1, 2};
   int          bTab [7] = '{3, 2, 3, 2, 2, 3, 2};
   int          sTab [7] = '{1, 2, 1, 1, 1, 1, 1};
   int          caTab [7] = '{0, -1, 0, -1, -1, -1, -1};
   int          cbTab [7] = '{255, -1, 255, -1, -1, -1, -1};
   always #12.5 mclk = ~mclk;
   tpw_timer dut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .waveOutA(waveOutA),
      .waveOutB(waveOutB), .pinOutA(pinOutA), .pinOeA(pinOeA), .pinOutB(pinOutB), .pinOeB(pinOeB));
   tpw_pad_load padModA (.pinOut(pinOutA), .pinOe(pinOeA), .padLevel(padA));
   tpw_pad_load padModB (.pinOut(pinOutB), .pinOe(pinOeB), .padLevel(padB));
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
      begin
         bad_count++;
         give_verdict();
      end
      // read data is registered, so it is taken one cycle after the access edge
      @(posedge mclk);
      rv = prdata;
   endtask
   // highs over two base periods, so toggle mode fits one window
   function automatic int high2(input int m, input int act, input int c, input int t);
      int b, h;
      b = m[1] ? t + 1 : 2 * t;
      h = m[1] ? c + 1 : 2 * c;
      if (act == 1)
         return b;
      return act == 3 ? 2 * (b - h) : 2 * h;
   endfunction
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (3) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      apb(0, TPW_OFS_CTRL, 0);
      check(rv, TPW_RST_REG);
      apb(0, TPW_OFS_PORT, 0);
      check(rv, TPW_RST_REG);
      apb(0, 8'h18, 0);
      check(er, 1);
      check(rv, 0);
      for (i = 0; i < 7; i++)
      begin
         ca = caTab[i] >= 0 ? caTab[i] : (mTab[i] > 4 ? 8 + {$random(seed)} % 248 : {$random(seed)} % 256);
         cb = cbTab[i] >= 0 ? cbTab[i] : {$random(seed)} % (mTab[i] > 4 ? ca : 256);
         top = mTab[i] > 4 ? ca : 255;
         fac = sTab[i] == 2 ? 8 : 1;
         base = mTab[i][1] ? top + 1 : 2 * top;
         win = 2 * base * fac;
         apb(1, TPW_OFS_CTRL, 0);
         apb(1, TPW_OFS_PORT, 32'h3);
         apb(1, TPW_OFS_CMPA, ca);
         apb(1, TPW_OFS_CMPB, cb);
         apb(1, TPW_OFS_COUNT, 0);
         apb(1, TPW_OFS_CTRL, (sTab[i] << 8) | (bTab[i] << 6) | (aTab[i] << 4) | mTab[i]);
         repeat (2 * win) @(posedge mclk);
         apb(1, TPW_OFS_STATUS, 32'h7);
         hiA = 0;
         hiB = 0;
         // sample mid-cycle where the pins are settled
         repeat (win)
         begin
            @(negedge mclk);
            hiA += padA;
            hiB += padB;
         end
         @(posedge mclk);
         check(hiA, high2(mTab[i], aTab[i], ca, top) * fac);
         check(hiB, high2(mTab[i], bTab[i], cb, top) * fac);
         apb(0, TPW_OFS_STATUS, 0);
         check(rv[TPW_ST_OVF], 1);
      end
      // toggle is refused on b and on a in fast pwm mode 3, which lacks mode bit 2
      apb(1, TPW_OFS_PORT, 32'hb);
      apb(1, TPW_OFS_CTRL, 32'h0153);
      hiA = 0;
      hiB = 0;
      repeat (600)
      begin
         @(negedge mclk);
         hiA += padA;
         hiB += padB;
      end
      @(posedge mclk);
      check(hiA, 0);
      check(hiB, 600);
      apb(1, TPW_OFS_CTRL, 32'h0103);
      apb(1, TPW_OFS_PORT, 32'h8);
      check(pinOutA, 0);
      check(pinOutB, 1);
      check(padA, 1);
      apb(1, TPW_OFS_PORT, 32'h9);
      check(padA, 0);
      check(padB, 1);
      give_verdict();
   end
endmodule
`default_nettype wire
